// ===== pkg/eeprom_defines.svh
// Constants for the two-wire serial memory target.
// Assumes a 40 MHz system clock that samples both bus lines.
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH

// ****************************************
// Addressing
// ****************************************
`define TYPE_CODE 4'hA
`define MEM_BYTES 65536
`define PAGE_BYTES 128
`define PAGE_IDX_W 7
`define PAGE_NUM_W 9
`define ADDR_W 16
`define ERASED_BYTE 8'hFF

// ****************************************
// Buffering
// ****************************************
`define FIFO_DEPTH 16
`define FIFO_WIDTH 15

// ****************************************
// Timing
// ****************************************
`define CLK_MHZ 40
`define TWR_MS 5
`define TWR_CYCLES (`TWR_MS * 1000 * `CLK_MHZ)
`define TIMER_W 18

`endif

// ===== pkg/eeprom_pkg.sv
// Types shared by the serial memory target.
// Assumes eeprom_defines.svh holds the numeric constants.
`default_nettype none

package eeprom_pkg;

   // Byte-level link state, Gray coded along the usual path
   typedef enum logic [2:0] {
      LINK_IDLE = 3'b000,
      LINK_DEV  = 3'b001,
      LINK_AHI  = 3'b011,
      LINK_ALO  = 3'b010,
      LINK_WR   = 3'b110,
      LINK_RD   = 3'b111,
      LINK_SKIP = 3'b101
   } link_state_e;

   // Internal programming cycle
   typedef enum logic [1:0] {
      PROG_IDLE   = 2'b00,
      PROG_WAIT   = 2'b01,
      PROG_COMMIT = 2'b11,
      PROG_TIMER  = 2'b10
   } prog_state_e;

endpackage

`default_nettype wire

// ===== rtl/serial_eeprom_i2c_slave.sv
// Two-wire serial memory target with a 128-byte page buffer.
// Assumes bus lines and straps are asynchronous and are sampled by clk_sys.
`default_nettype none

`include "eeprom_defines.svh"

// ****************************************
// Write data FIFO
// ****************************************
module eeprom_fifo #(
   parameter int WIDTH = `FIFO_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] store_ff [DEPTH];
   logic [PW:0] wptr_ff;
   logic [PW:0] rptr_ff;
   wire full = (wptr_ff[PW] != rptr_ff[PW]) &&
               (wptr_ff[PW-1:0] == rptr_ff[PW-1:0]);
   wire empty = (wptr_ff == rptr_ff);
   wire do_push = in_valid && !full;
   wire do_pop = out_ready && !empty;

   // Handshake flags
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = store_ff[rptr_ff[PW-1:0]];

   // Storage, no reset needed for data
   always_ff @(posedge clk_sys) begin
      if (do_push) begin
         store_ff[wptr_ff[PW-1:0]] <= in_data;
      end
   end

   // Pointers carry a wrap bit for honest full and empty
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wptr_ff <= '0;
         rptr_ff <= '0;
      end else begin
         if (do_push) wptr_ff <= wptr_ff + 1'b1;
         if (do_pop) rptr_ff <= rptr_ff + 1'b1;
      end
   end
endmodule // eeprom_fifo

// ****************************************
// Serial memory target
// ****************************************
module serial_eeprom_i2c_slave #(
   parameter int WRITE_CYCLES = `TWR_CYCLES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   // Straps and protection
   input wire logic addr_select_bit0,
   input wire logic addr_select_bit1,
   input wire logic addr_select_bit2,
   input wire logic wp_i,
   // Status
   output logic busy_o
);
   eeprom_pkg::link_state_e state_ff;
   eeprom_pkg::link_state_e nxt_state;
   eeprom_pkg::prog_state_e prog_ff;

   logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
   logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
   logic [3:0] pin_s1_ff;
   logic [3:0] pin_s2_ff;
   logic [3:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic out_low_ff;
   logic acc_ff, rw_ff, mack_ff;
   logic wp_lat_ff, has_data_ff, reject_ff;
   logic [`ADDR_W-1:0] addr_ff;
   logic [`PAGE_NUM_W-1:0] page_ff;
   logic [`PAGE_IDX_W-1:0] commit_idx_ff;
   logic [`TIMER_W-1:0] timer_ff;
   logic [7:0] mem_ff [`MEM_BYTES] = '{default: `ERASED_BYTE};
   logic [7:0] pbuf_ff [`PAGE_BYTES];
   logic [`PAGE_BYTES-1:0] pval_ff;
   logic fifo_in_ready, fifo_out_valid;
   logic [`FIFO_WIDTH-1:0] fifo_out_data;

   // ****************************************
   // Pin synchronisers
   // ****************************************
   // Two flops per pin; third flop only keeps history for edges
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scl_s1_ff <= 1'b1;
         scl_s2_ff <= 1'b1;
         scl_s3_ff <= 1'b1;
         sda_s1_ff <= 1'b1;
         sda_s2_ff <= 1'b1;
         sda_s3_ff <= 1'b1;
         pin_s1_ff <= 4'h0;
         pin_s2_ff <= 4'h0;
      end else begin
         scl_s1_ff <= scl_i;
         scl_s2_ff <= scl_s1_ff;
         scl_s3_ff <= scl_s2_ff;
         sda_s1_ff <= sda_i;
         sda_s2_ff <= sda_s1_ff;
         sda_s3_ff <= sda_s2_ff;
         pin_s1_ff <= {wp_i, addr_select_bit2, addr_select_bit1,
                       addr_select_bit0};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   // ****************************************
   // Bus conditions and decode
   // ****************************************
   // Edges and conditions from the synchronised lines
   wire scl_hi = scl_s2_ff && scl_s3_ff;
   wire start_det = scl_hi && sda_s3_ff && !sda_s2_ff;
   wire stop_det = scl_hi && !sda_s3_ff && sda_s2_ff;
   wire scl_rise = scl_s2_ff && !scl_s3_ff;
   wire scl_fall = !scl_s2_ff && scl_s3_ff;
   wire wp_pin = pin_s2_ff[3];
   wire busy = (prog_ff != eeprom_pkg::PROG_IDLE);

   // Byte phase decode
   wire active = (state_ff != eeprom_pkg::LINK_IDLE) &&
                 (state_ff != eeprom_pkg::LINK_SKIP);
   wire bit_rise = active && scl_rise && (bit_cnt_ff < 4'd8);
   wire ack_rise = active && scl_rise && (bit_cnt_ff == 4'd8);
   wire ack_fall = active && scl_fall && (bit_cnt_ff == 4'd8);
   wire end_fall = active && scl_fall && (bit_cnt_ff == 4'd9);
   wire data_fall = scl_fall && (state_ff == eeprom_pkg::LINK_RD) &&
                    (bit_cnt_ff != 4'd0) && (bit_cnt_ff < 4'd8);
   wire in_dev = (state_ff == eeprom_pkg::LINK_DEV);
   wire in_ahi = (state_ff == eeprom_pkg::LINK_AHI);
   wire in_alo = (state_ff == eeprom_pkg::LINK_ALO);
   wire in_wr = (state_ff == eeprom_pkg::LINK_WR);
   wire in_rd = (state_ff == eeprom_pkg::LINK_RD);

   // Address match and acceptance
   wire dev_match = (shift_ff[7:4] == `TYPE_CODE) &&
                    (shift_ff[3:1] == pin_s2_ff[2:0]);
   wire dev_ack = dev_match && !busy;
   wire wr_ok = !wp_lat_ff && fifo_in_ready;
   wire push = ack_fall && in_wr && wr_ok;
   wire load_rd = end_fall && ((in_dev && acc_ff && rw_ff) ||
                               (in_rd && mack_ff));
   wire [7:0] mem_rd = mem_ff[addr_ff];
   wire pbuf_clr = end_fall && in_alo;
   wire commit_req = stop_det && has_data_ff && !reject_ff;

   // Open drain: data pin is only ever pulled low
   assign sda_o = 1'b0;
   assign sda_oe_n = !out_low_ff;
   assign busy_o = busy;

   // ****************************************
   // Link state machine
   // ****************************************
   // Next byte phase; START and STOP override any phase
   always_comb begin
      nxt_state = state_ff;
      if (start_det) begin
         nxt_state = eeprom_pkg::LINK_DEV;
      end else if (stop_det) begin
         nxt_state = eeprom_pkg::LINK_IDLE;
      end else if (end_fall) begin
         unique case (state_ff)
            eeprom_pkg::LINK_DEV: begin
               if (!acc_ff) nxt_state = eeprom_pkg::LINK_SKIP;
               else if (rw_ff) nxt_state = eeprom_pkg::LINK_RD;
               else nxt_state = eeprom_pkg::LINK_AHI;
            end
            eeprom_pkg::LINK_AHI: nxt_state = eeprom_pkg::LINK_ALO;
            eeprom_pkg::LINK_ALO: nxt_state = eeprom_pkg::LINK_WR;
            eeprom_pkg::LINK_WR: begin
               if (reject_ff) nxt_state = eeprom_pkg::LINK_SKIP;
            end
            eeprom_pkg::LINK_RD: begin
               if (!mack_ff) nxt_state = eeprom_pkg::LINK_SKIP;
            end
            default: nxt_state = eeprom_pkg::LINK_SKIP;
         endcase
      end
   end

   // State and bit counter
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_ff <= eeprom_pkg::LINK_IDLE;
         bit_cnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         if (start_det || end_fall) bit_cnt_ff <= 4'h0;
         else if (bit_rise || ack_rise) bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
   end

   // Receive shifter and master acknowledge capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         shift_ff <= 8'h00;
         mack_ff <= 1'b0;
      end else begin
         if (bit_rise) shift_ff <= {shift_ff[6:0], sda_s2_ff};
         if (ack_rise) mack_ff <= !sda_s2_ff;
      end
   end

   // Address byte verdict, held through the ack slot
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         acc_ff <= 1'b0;
         rw_ff <= 1'b0;
      end else if (ack_fall && in_dev) begin
         acc_ff <= dev_ack;
         rw_ff <= shift_ff[0];
      end
   end

   // ****************************************
   // Data line drive
   // ****************************************
   // Changes only on falling clock; released at START and STOP
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         out_low_ff <= 1'b0;
      end else if (start_det || stop_det) begin
         out_low_ff <= 1'b0;
      end else if (ack_fall) begin
         if (in_dev) out_low_ff <= dev_ack;
         else if (in_ahi || in_alo) out_low_ff <= 1'b1;
         else if (in_wr) out_low_ff <= wr_ok;
         else out_low_ff <= 1'b0;
      end else if (end_fall) begin
         out_low_ff <= load_rd && !mem_rd[7];
      end else if (data_fall) begin
         out_low_ff <= !tx_ff[3'd7 - bit_cnt_ff[2:0]];
      end
   end

   // ****************************************
   // Address counter and read data
   // ****************************************
   // Write increments wrap in page; reads wrap over all memory
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addr_ff <= '0;
         page_ff <= '0;
         tx_ff <= 8'h00;
      end else begin
         if (ack_fall && in_ahi) addr_ff[15:8] <= shift_ff;
         if (ack_fall && in_alo) begin
            addr_ff[7:0] <= shift_ff;
            page_ff <= {addr_ff[15:8], shift_ff[7]};
         end
         if (push) begin
            addr_ff[6:0] <= addr_ff[6:0] + 7'h01;
         end
         if (load_rd) begin
            tx_ff <= mem_rd;
            addr_ff <= addr_ff + 16'h0001;
         end
      end
   end

   // Protect strobe and write bookkeeping for this command
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wp_lat_ff <= 1'b0;
         has_data_ff <= 1'b0;
         reject_ff <= 1'b0;
      end else if (start_det) begin
         has_data_ff <= 1'b0;
         reject_ff <= 1'b0;
      end else begin
         if (pbuf_clr) wp_lat_ff <= wp_pin;
         if (push) has_data_ff <= 1'b1;
         if (ack_fall && in_wr && !wr_ok) reject_ff <= 1'b1;
      end
   end

   // ****************************************
   // Page buffer
   // ****************************************
   // FIFO decouples bus bytes from page buffer; full means not acked
   wire drain_ready = (prog_ff != eeprom_pkg::PROG_COMMIT);
   wire drain_we = fifo_out_valid && drain_ready;
   wire [`PAGE_IDX_W-1:0] drain_idx = fifo_out_data[14:8];
   wire commit_done = (prog_ff == eeprom_pkg::PROG_COMMIT) &&
                      (commit_idx_ff == 7'h7F);
   wire commit_we = (prog_ff == eeprom_pkg::PROG_COMMIT) &&
                    pval_ff[commit_idx_ff];

   eeprom_fifo #(
      .WIDTH(`FIFO_WIDTH),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data({addr_ff[6:0], shift_ff}),
      .out_valid(fifo_out_valid),
      .out_ready(drain_ready),
      .out_data(fifo_out_data)
   );

   // Later bytes at one index replace earlier ones
   always_ff @(posedge clk_sys) begin
      if (drain_we) pbuf_ff[drain_idx] <= fifo_out_data[7:0];
   end

   // Valid flag per page entry; a set beats a clear
   for (genvar i = 0; i < `PAGE_BYTES; i++) begin : g_pval
      always_ff @(posedge clk_sys or negedge rstn) begin
         if (!rstn) pval_ff[i] <= 1'b0;
         else if (drain_we && (drain_idx == i)) pval_ff[i] <= 1'b1;
         else if (pbuf_clr || commit_done) pval_ff[i] <= 1'b0;
      end
   end

   // ****************************************
   // Programming cycle
   // ****************************************
   // Wait for FIFO to empty, copy page, then hold busy
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prog_ff <= eeprom_pkg::PROG_IDLE;
         commit_idx_ff <= '0;
         timer_ff <= '0;
      end else begin
         unique case (prog_ff)
            eeprom_pkg::PROG_IDLE: begin
               if (commit_req) prog_ff <= eeprom_pkg::PROG_WAIT;
            end
            eeprom_pkg::PROG_WAIT: begin
               commit_idx_ff <= '0;
               if (!fifo_out_valid) prog_ff <= eeprom_pkg::PROG_COMMIT;
            end
            eeprom_pkg::PROG_COMMIT: begin
               commit_idx_ff <= commit_idx_ff + 7'h01;
               if (commit_done) begin
                  prog_ff <= eeprom_pkg::PROG_TIMER;
                  timer_ff <= `TIMER_W'(WRITE_CYCLES - `PAGE_BYTES - 2);
               end
            end
            eeprom_pkg::PROG_TIMER: begin
               timer_ff <= timer_ff - 1'b1;
               if (timer_ff == '0) prog_ff <= eeprom_pkg::PROG_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Memory array
   // ****************************************
   // Nonvolatile model: no reset, so contents survive rstn.
   // Erased contents come from the declaration, so the commit process
   // stays the only writer of the array.
   // One page byte per cycle during commit
   always_ff @(posedge clk_sys) begin
      if (commit_we) begin
         mem_ff[{page_ff, commit_idx_ff}] <= pbuf_ff[commit_idx_ff];
      end
   end

endmodule // serial_eeprom_i2c_slave

`default_nettype wire

// ===== verif/serial_eeprom_i2c_slave_chk.sv
// Port checker for the serial memory target.
// Assumes bus pins change just after clk_sys edges, never on them.
`default_nettype none
// ****
// Checker
// ****
module serial_eeprom_i2c_slave_chk #(
   parameter int WRITE_CYCLES = 200000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // Serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   // Straps and protection
   input wire logic addr_select_bit0,
   input wire logic addr_select_bit1,
   input wire logic addr_select_bit2,
   input wire logic wp_i,
   // Status
   input wire logic busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_ff, sda_ff, go_ff, rw_ff, wpc_ff, wd_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff, byt_ff, stp_ff;
   logic [31:0] bsy_ff;
   // Bus events seen on the raw pins
   wire logic rise = scl_i && !scl_ff;
   wire logic fall = !scl_i && scl_ff;
   wire logic start = scl_i && scl_ff && sda_ff && !sda_i;
   wire logic stop = scl_i && scl_ff && !sda_ff && sda_i;
   wire logic ninth = rise && bit_ff == 4'h8;
   wire logic [6:0] own = {4'hA, addr_select_bit2, addr_select_bit1,
      addr_select_bit0};
   // Pin history, busy length, cycles since STOP
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         scl_ff <= 1'b1;
         sda_ff <= 1'b1;
         bsy_ff <= 32'h0;
         stp_ff <= 8'hFF;
      end else begin
         scl_ff <= scl_i;
         sda_ff <= sda_i;
         bsy_ff <= busy_o ? bsy_ff + 32'h1 : 32'h0;
         stp_ff <= stop ? 8'h0 : stp_ff + {7'h0, stp_ff != 8'hFF};
      end
   end
   // Bit and byte position since the last START
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         go_ff <= 1'b0;
         bit_ff <= 4'h0;
         byt_ff <= 8'h0;
         wd_ff <= 1'b0;
      end else if (start) begin
         go_ff <= 1'b1;
         bit_ff <= 4'h0;
         byt_ff <= 8'h0;
         wd_ff <= 1'b0;
      end else begin
         if (rise) bit_ff <= (bit_ff == 4'h8) ? 4'h0 : bit_ff + 4'h1;
         if (ninth && byt_ff != 8'hFF) byt_ff <= byt_ff + 8'h1;
         if (ninth && byt_ff > 8'h2 && !rw_ff && !sda_oe_n) wd_ff <= 1'b1;
      end
   end
   // Shift data and strobe captures; no reset needed
   always_ff @(posedge clk_sys) begin
      if (rise) sh_ff <= {sh_ff[6:0], sda_i};
      if (rise && bit_ff == 4'h7 && byt_ff == 8'h0) rw_ff <= sda_i;
      if (fall && byt_ff == 8'h3 && bit_ff == 4'h0) wpc_ff <= wp_i;
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   property p_od_low; sda_o == 1'b0; endproperty
   a_od_low: assert property (p_od_low)
      else $error("data output not low");
   property p_edge; $changed(sda_oe_n) |-> !scl_i && !scl_ff; endproperty
   a_edge: assert property (p_edge)
      else $error("data changed outside clock low");
   property p_no_start; !go_ff |-> sda_oe_n; endproperty
   a_no_start: assert property (p_no_start)
      else $error("drive before any start");
   property p_match; ninth && byt_ff == 8'h0 && !sda_oe_n |->
      sh_ff[7:1] == own; endproperty
   a_match: assert property (p_match)
      else $error("foreign address acknowledged");
   property p_ack; ninth && byt_ff == 8'h0 && sh_ff[7:1] == own &&
      !busy_o && !$past(busy_o, 8) |-> !sda_oe_n; endproperty
   a_ack: assert property (p_ack)
      else $error("own address not acknowledged");
   property p_rd_rel; ninth && rw_ff && byt_ff != 8'h0 |-> sda_oe_n;
   endproperty
   a_rd_rel: assert property (p_rd_rel)
      else $error("line held in read ninth clock");
   property p_busy_quiet; busy_o |-> sda_oe_n; endproperty
   a_busy_quiet: assert property (p_busy_quiet)
      else $error("drive while busy");
   property p_prog; stop && wd_ff |-> ##[1:8] busy_o; endproperty
   a_prog: assert property (p_prog)
      else $error("no write cycle after stop");
   property p_cause; $rose(busy_o) |-> wd_ff && stp_ff <= 8'h8;
   endproperty
   a_cause: assert property (p_cause)
      else $error("write cycle without data");
   property p_len; $fell(busy_o) |-> bsy_ff >= 32'(WRITE_CYCLES - 8) &&
      bsy_ff <= 32'(WRITE_CYCLES + 40); endproperty
   a_len: assert property (p_len)
      else $error("write cycle length off");
   property p_wp; ninth && byt_ff == 8'h3 && !rw_ff && wpc_ff |-> sda_oe_n;
   endproperty
   a_wp: assert property (p_wp)
      else $error("protected data acknowledged");
endmodule // serial_eeprom_i2c_slave_chk

bind serial_eeprom_i2c_slave serial_eeprom_i2c_slave_chk #(
   .WRITE_CYCLES(WRITE_CYCLES)
) i_chk (
   .clk_sys(clk_sys), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_select_bit0(addr_select_bit0),
   .addr_select_bit1(addr_select_bit1), .addr_select_bit2(addr_select_bit2),
   .wp_i(wp_i), .busy_o(busy_o));
`default_nettype wire

// ===== verif/bus_ctrl_model.sv
// Behavioural two-wire bus controller; it owns the serial clock.
// Assumes the bench resolves the data wire with a pull-up.
`default_nettype none
// ****
// Controller model
// ****
module bus_ctrl_model (
   // Bus pins
   output var logic scl,
   output var logic sda_drv,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int Q = 50;
   // Clock stands high and data released outside frames
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // START, or repeated START when entered with the clock low
   task automatic t_start();
      #Q sda_drv = 1'b1;
      #Q scl = 1'b1;
      #(2 * Q) sda_drv = 1'b0;
      #(2 * Q) scl = 1'b0;
   endtask
   // STOP, entered with the clock low
   task automatic t_stop();
      #Q sda_drv = 1'b0;
      #Q scl = 1'b1;
      #(2 * Q) sda_drv = 1'b1;
      #(2 * Q);
   endtask
   // Data moves only while the clock is low, so no false condition
   task automatic t_bit(input logic b, output logic r);
      #Q sda_drv = b;
      #Q scl = 1'b1;
      #Q r = sda_line;
      #Q scl = 1'b0;
   endtask
   // Byte MSB first, then the ninth bit; a 1 releases the line
   task automatic t_byte(input logic [7:0] d, input logic a_in,
      output logic [7:0] q, output logic a_out);
      for (int i = 7; i >= 0; i--) begin
         t_bit(d[i], q[i]);
      end
      t_bit(a_in, a_out);
   endtask
endmodule // bus_ctrl_model
`default_nettype wire

// ===== verif/serial_eeprom_i2c_slave_tb.sv
// Self-checking bench for the serial memory target.
// Assumes the design, checker and bus_ctrl_model are compiled first.
`default_nettype none
// ****
// Bench
// ****
module serial_eeprom_i2c_slave_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WCYC = 300; // Short write cycle keeps polling brief
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic wp = 1'b0;
   logic [2:0] strap = 3'h0;
   wire logic scl, sda_drv, sda_line;
   logic sda_o, sda_oe_n, busy, ack;
   logic [7:0] q;
   int err_total = 0;
   int num_checks = 0;
   int tries;
   logic [31:0] rng = 32'h94E9F80E;
   logic [31:0] v;
   logic [15:0] pa;
   logic [7:0] ref_mem [int];
   // Open-drain wire with pull-up
   assign sda_line = sda_drv & (sda_oe_n | sda_o);
   always #12.5 clk_sys = ~clk_sys;
   serial_eeprom_i2c_slave #(.WRITE_CYCLES(WCYC)) i_dut (
      .clk_sys(clk_sys), .rstn(rstn), .scl_i(scl), .sda_i(sda_line),
      .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_select_bit0(strap[0]),
      .addr_select_bit1(strap[1]), .addr_select_bit2(strap[2]),
      .wp_i(wp), .busy_o(busy));
   bus_ctrl_model i_ctrl (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_line));
   // Expectation helpers
   function automatic logic [7:0] exp_byte(input logic [15:0] a);
      return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 8'hFF;
   endfunction
   function automatic logic [7:0] dev(input logic rd);
      return {4'hA, strap, rd};
   endfunction
   task automatic rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      v = rng;
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Target address for write, then both address bytes
   task automatic adr(input logic [15:0] a);
      i_ctrl.t_start();
      for (int i = 0; i < 3; i++) begin
         i_ctrl.t_byte(i == 0 ? dev(1'b0) : (i == 1 ? a[15:8] : a[7:0]),
            1'b1, q, ack);
         chk1(ack, 1'b0);
      end
   endtask
   // Random data write; the model page wraps like the memory should
   task automatic wr(input logic [15:0] a, input int n);
      adr(a);
      for (int i = 0; i < n; i++) begin
         rnd();
         i_ctrl.t_byte(v[7:0], 1'b1, q, ack);
         chk1(ack, wp);
         if (!wp) ref_mem[int'({a[15:7], 7'(a[6:0] + i)})] = v[7:0];
      end
      i_ctrl.t_stop();
   endtask
   // Selective or immediate read of n bytes, NACK on the last
   task automatic rd(input logic sel, input logic [15:0] a, input int n);
      if (sel) adr(a);
      i_ctrl.t_start();
      i_ctrl.t_byte(dev(1'b1), 1'b1, q, ack);
      chk1(ack, 1'b0);
      for (int i = 0; i < n; i++) begin
         i_ctrl.t_byte(8'hFF, i == n - 1, q, ack);
         chk8(q, exp_byte(a + 16'(i)));
      end
      i_ctrl.t_stop();
   endtask
   // Address polling until the write cycle ends
   task automatic poll();
      tries = 0;
      ack = 1'b1;
      while (ack && tries < 40) begin
         tries++;
         i_ctrl.t_start();
         i_ctrl.t_byte(dev(1'b0), 1'b1, q, ack);
         i_ctrl.t_stop();
      end
      chk1(ack, 1'b0);
      chk1(tries > 1, 1'b1);
   endtask
   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rnd();
      strap = v[2:0];
      tick(4);
      rstn = 1'b1;
      tick(4);
      chk1(busy, 1'b0);
      chk1(sda_oe_n, 1'b1);
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         i_ctrl.t_start();
         i_ctrl.t_byte(k == 0 ? {4'hB, strap, 1'b0} :
            {4'hA, strap ^ 3'(k), 1'b0}, 1'b1, q, ack);
         chk1(ack, 1'b1);
         i_ctrl.t_stop();
      end
      rnd();
      rd(1'b1, v[15:0], 2);
      $display("test address done");
      rnd();
      pa = {v[15:7], 7'h7E};
      wr(pa, 130);
      tick(8);
      chk1(busy, 1'b1);
      i_ctrl.t_start();
      i_ctrl.t_byte(dev(1'b1), 1'b1, q, ack);
      chk1(ack, 1'b1);
      i_ctrl.t_stop();
      poll();
      rd(1'b1, {pa[15:7], 7'h0}, 128);
      rd(1'b0, {pa[15:7], 7'h0} + 16'h80, 1);
      $display("test page done");
      rnd();
      pa = v[15:0];
      wr(pa, 1);
      poll();
      wp = 1'b1;
      wr(pa, 1);
      tick(8);
      chk1(busy, 1'b0);
      wp = 1'b0;
      rd(1'b1, pa, 1);
      $display("test protect done");
      rnd();
      pa = v[15:0];
      adr(pa);
      i_ctrl.t_stop();
      tick(8);
      chk1(busy, 1'b0);
      rd(1'b0, pa, 1);
      rd(1'b1, 16'hFFFF, 2);
      rd(1'b0, 16'h0001, 1);
      $display("test counter done");
      wrap_up();
   end
   // Watchdog: run needs about 0.6 ms
   initial begin
      #2_000_000;
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      wrap_up();
   end
endmodule // serial_eeprom_i2c_slave_tb
`default_nettype wire
